// ===== include/lsc_pkg.sv
// constants, field layout and tap tables of the sequence counter
package lsc_pkg;

    localparam int          LSC_W          = 32;
    localparam int          LSC_BANKS      = 4;

    // register byte offsets
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STATE      = 8'h04;
    localparam logic [7:0]  OFF_DELAY      = 8'h08;
    localparam logic [7:0]  OFF_STATUS     = 8'h0c;
    localparam logic [7:0]  OFF_LOAD0      = 8'h10;
    localparam logic [7:0]  OFF_END0       = 8'h20;

    // control field positions
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          CTRL_XNOR_BIT  = 1;
    localparam int          CTRL_LEN_LSB   = 2;
    localparam int          CTRL_AUTO_BIT  = 5;
    localparam int          CTRL_LOAD_BIT  = 6;
    localparam int          CTRL_MOD_LSB   = 8;
    localparam logic [31:0] CTRL_WMASK     = 32'h0000_033f;

    // length select codes
    localparam logic [2:0]  LEN_SEL_4      = 3'h0;
    localparam logic [2:0]  LEN_SEL_8      = 3'h1;
    localparam logic [2:0]  LEN_SEL_9      = 3'h2;
    localparam logic [2:0]  LEN_SEL_16     = 3'h3;
    localparam logic [2:0]  LEN_SEL_24     = 3'h4;
    localparam logic [2:0]  LEN_SEL_31     = 3'h5;

    // tap masks, stage k sits at bit k-1; multitap lists number bits from zero,
    // so their last listed tap is the last stage and the cycle stays maximal
    localparam logic [31:0] TAP_4          = 32'h0000_0009;
    localparam logic [31:0] TAP_8          = 32'h0000_00b8;
    localparam logic [31:0] TAP_9          = 32'h0000_0110;
    localparam logic [31:0] TAP_16         = 32'h0000_b400;
    localparam logic [31:0] TAP_24         = 32'h00e1_0000;
    localparam logic [31:0] TAP_31         = 32'h4800_0000;

    // values after reset
    localparam logic [31:0] CTRL_RST       = 32'h0000_0028;
    localparam logic [31:0] LFSR_RST       = 32'h0000_0001;
    localparam logic [31:0] LOAD_RST       = 32'h0000_0001;
    localparam logic [31:0] END_RST        = 32'h0000_0080;

    function automatic logic [31:0] lsc_len_mask(input logic [2:0] s);
        case (s)
            LEN_SEL_4:  return 32'h0000_000f;
            LEN_SEL_8:  return 32'h0000_00ff;
            LEN_SEL_16: return 32'h0000_ffff;
            LEN_SEL_24: return 32'h00ff_ffff;
            LEN_SEL_31: return 32'h7fff_ffff;
            default:    return 32'h0000_01ff;
        endcase
    endfunction

    function automatic logic [31:0] lsc_tap_mask(input logic [2:0] s);
        case (s)
            LEN_SEL_4:  return TAP_4;
            LEN_SEL_8:  return TAP_8;
            LEN_SEL_16: return TAP_16;
            LEN_SEL_24: return TAP_24;
            LEN_SEL_31: return TAP_31;
            default:    return TAP_9;
        endcase
    endfunction

    function automatic logic lsc_in_bank(input logic [7:0] a, input logic [7:0] base);
        return a[7:4] == base[7:4];
    endfunction

endpackage

// ===== hdl/lsc_muxed_flipflop_with_enable.sv
// one loadable shift stage: d flip-flop behind a two-way input mux
`timescale 1ns/100ps
module lsc_muxed_flipflop_with_enable #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // controls
    input  wire logic load_in,
    input  wire logic enable_in,
    // data
    input  wire logic load_d_in,
    input  wire logic shift_d_in,
    output logic      q_out
);

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            q_out <= RST_VAL;
        else if (load_in)
            q_out <= load_d_in;
        else if (enable_in)
            q_out <= shift_d_in;
    end

endmodule // lsc_muxed_flipflop_with_enable

// ===== hdl/lsc_sequence_counter.sv
// pseudo-random sequence counter with ahb-lite register slave
`timescale 1ns/100ps
module lsc_sequence_counter #(
    parameter int MAX_DELAY = 7
) (
    // clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    // ahb-lite slave
    input  wire logic                       hsel_in,
    input  wire logic [31:0]                haddr_in,
    input  wire logic [1:0]                 htrans_in,
    input  wire logic                       hwrite_in,
    input  wire logic [2:0]                 hsize_in,
    input  wire logic                       hready_in,
    input  wire logic [31:0]                hwdata_in,
    output logic      [31:0]                hrdata_out,
    output logic                            hreadyout_out,
    output logic                            hresp_out,
    // cascade and sequence
    input  wire logic                       cascade_en_in,
    output logic                            tc_out,
    output logic      [lsc_pkg::LSC_W-1:0]  state_out
);
    import lsc_pkg::*;

    localparam int DW = (MAX_DELAY < 2) ? 1 : $clog2(MAX_DELAY + 1);

    if (MAX_DELAY < 1 || MAX_DELAY > 15)
    begin : g_check
        $error("MAX_DELAY must lie in 1..15");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0]    ctrl;
    logic [31:0]    load_val [LSC_BANKS];
    logic [31:0]    end_val  [LSC_BANKS];
    logic [DW-1:0]  dly;
    logic [15:0]    tc_count;
    logic           wr_pend;
    logic           rd_pend;
    logic [7:0]     ph_addr;
    logic           sw_load;
    logic [MAX_DELAY-1:0] det_pipe;
    logic [LSC_W-1:0] q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        addr_ok   = hsel_in & htrans_in[1] & hready_in;
    wire        wr_ctrl   = wr_pend & (ph_addr == OFF_CTRL);
    wire        wr_delay  = wr_pend & (ph_addr == OFF_DELAY);
    wire        wr_status = wr_pend & (ph_addr == OFF_STATUS);
    wire        wr_load   = wr_pend & lsc_in_bank(ph_addr, OFF_LOAD0);
    wire        wr_end    = wr_pend & lsc_in_bank(ph_addr, OFF_END0);
    wire [1:0]  bank_idx  = ph_addr[3:2];
    wire [DW-1:0] dly_wr  = (hwdata_in > 32'(MAX_DELAY)) ? DW'(MAX_DELAY) : hwdata_in[DW-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // control fields
    wire        run       = ctrl[CTRL_RUN_BIT];
    wire        xnor_mode = ctrl[CTRL_XNOR_BIT];
    wire        auto_rld  = ctrl[CTRL_AUTO_BIT];
    wire [2:0]  len_sel   = ctrl[CTRL_LEN_LSB +: 3];
    wire [1:0]  mod_sel   = ctrl[CTRL_MOD_LSB +: 2];
    wire [31:0] len_mask  = lsc_len_mask(len_sel);
    wire [31:0] tap_mask  = lsc_tap_mask(len_sel);
    wire [31:0] lock_pat  = xnor_mode ? len_mask : 32'h0;
    wire [31:0] q_masked  = q & len_mask;

    ////////////////////////////////////////////////////////////////////////////
    // feedback, detection and load selection
    // one parity tree over masked taps: longer lengths add stages, not levels
    wire        fb_par    = ^(q & tap_mask);
    wire        fb        = fb_par ^ xnor_mode;
    wire [31:0] start_sel = load_val[mod_sel] & len_mask;
    wire [31:0] end_sel   = end_val[mod_sel] & len_mask;
    // a start value equal to the lock state would freeze the counter
    wire        lock_hit  = (start_sel == lock_pat);
    wire [31:0] load_value = start_sel ^ {31'h0, lock_hit};
    wire        load_now  = sw_load | (tc_out & auto_rld);
    wire        count_en  = run & cascade_en_in;
    wire        step      = count_en & ~load_now;
    wire        match     = (q_masked == end_sel);
    wire        detect    = match & step;
    wire [MAX_DELAY:0] det_vec = {det_pipe, detect};

    ////////////////////////////////////////////////////////////////////////////
    // shift stages
    for (genvar i = 0; i < LSC_W; i++)
    begin : g_stage
        wire shift_d = (i == 0) ? fb : (len_mask[i] & q[(i == 0) ? 0 : i - 1]);
        lsc_muxed_flipflop_with_enable #(
            .RST_VAL    (LFSR_RST[i])
        ) u_stage (
            .ref_clk_in (ref_clk_in),
            .rst_in     (rst_in),
            .load_in    (load_now),
            .enable_in  (count_en),
            .load_d_in  (load_value[i]),
            .shift_d_in (shift_d),
            .q_out      (q[i])
        );
    end

    assign state_out     = q;
    assign hreadyout_out = ~rd_pend;
    assign hresp_out     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // bus phases; reads take one wait state so that they see a write just before
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ph_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_ok & hwrite_in;
            rd_pend <= addr_ok & ~hwrite_in;
            if (addr_ok)
                ph_addr <= haddr_in[7:0];
        end
    end

    wire [31:0] rd_word =
        (ph_addr == OFF_CTRL)          ? ctrl :
        (ph_addr == OFF_STATE)         ? q_masked :
        (ph_addr == OFF_DELAY)         ? 32'(dly) :
        (ph_addr == OFF_STATUS)        ? {16'h0, tc_count} :
        lsc_in_bank(ph_addr, OFF_LOAD0) ? load_val[bank_idx] :
        lsc_in_bank(ph_addr, OFF_END0)  ? end_val[bank_idx] : 32'h0;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            hrdata_out <= 32'h0;
        else if (rd_pend)
            hrdata_out <= rd_word;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl    <= CTRL_RST;
            dly     <= '0;
            sw_load <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= hwdata_in & CTRL_WMASK;
            if (wr_delay)
                dly <= dly_wr;
            sw_load <= wr_ctrl & hwdata_in[CTRL_LOAD_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            load_val <= '{default: LOAD_RST};
            end_val  <= '{default: END_RST};
        end
        else
        begin
            if (wr_load)
                load_val[bank_idx] <= hwdata_in;
            if (wr_end)
                end_val[bank_idx] <= hwdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // end detection pipeline and terminal count
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            det_pipe <= '0;
            tc_out   <= 1'b0;
        end
        else
        begin
            det_pipe <= det_vec[MAX_DELAY-1:0];
            tc_out   <= det_vec[dly];
        end
    end

    // a terminal count in the clearing cycle still counts
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            tc_count <= 16'h0;
        else if (wr_status)
            tc_count <= {15'h0, tc_out};
        else if (tc_out)
            tc_count <= 16'(tc_count + 16'h1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    wire [31:0] hi_mask = len_mask & ~32'h1;

    property p_feedback;
        step |=> q[0] == $past(fb);
    endproperty
    a_feedback: assert property (p_feedback) else $error("stage one missed feedback");

    property p_shift;
        step |=> (q & $past(hi_mask)) == (($past(q) << 1) & $past(hi_mask));
    endproperty
    a_shift: assert property (p_shift) else $error("stages did not shift");

    property p_hold;
        !count_en && !load_now |=> $stable(q);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while disabled");

    property p_load;
        load_now |=> q == $past(load_value);
    endproperty
    a_load: assert property (p_load) else $error("load value not taken");

    property p_nolock;
        load_now |=> (q & $past(len_mask)) != $past(lock_pat);
    endproperty
    a_nolock: assert property (p_nolock) else $error("lock state loaded");

    sequence s_det0;
        detect && dly == 0;
    endsequence
    property p_tc0;
        s_det0 |=> tc_out;
    endproperty
    a_tc0: assert property (p_tc0) else $error("terminal count late, no delay");

    sequence s_det3;
        (detect && dly == 3) ##1 $stable(dly) [*3];
    endsequence
    property p_tc3;
        s_det3 |=> tc_out;
    endproperty
    a_tc3: assert property (p_tc3) else $error("terminal count late, delay three");

    property p_reload;
        tc_out && auto_rld |=> q == $past(load_value);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload at end");

    property p_len4;
        len_sel == LEN_SEL_4 && !xnor_mode |-> fb == (q[0] ^ q[3]);
    endproperty
    a_len4: assert property (p_len4) else $error("4-bit taps wrong");

    property p_len8;
        len_sel == LEN_SEL_8 && !xnor_mode |-> fb == ^{q[3], q[4], q[5], q[7]};
    endproperty
    a_len8: assert property (p_len8) else $error("8-bit taps wrong");

    property p_len9;
        len_sel == LEN_SEL_9 && xnor_mode |-> fb == !(q[4] ^ q[8]);
    endproperty
    a_len9: assert property (p_len9) else $error("9-bit taps wrong");

    property p_len16;
        len_sel == LEN_SEL_16 && !xnor_mode |-> fb == ^{q[10], q[12], q[13], q[15]};
    endproperty
    a_len16: assert property (p_len16) else $error("16-bit taps wrong");

    property p_len24;
        len_sel == LEN_SEL_24 && !xnor_mode |-> fb == ^{q[16], q[21], q[22], q[23]};
    endproperty
    a_len24: assert property (p_len24) else $error("24-bit taps wrong");

    property p_len31;
        len_sel == LEN_SEL_31 |-> fb == (q[27] ^ q[30] ^ xnor_mode);
    endproperty
    a_len31: assert property (p_len31) else $error("31-bit taps wrong");

endmodule // lsc_sequence_counter

// ===== bench/lsc_sequence_counter_bench.sv
// self-checking testbench of the pseudo-random sequence counter
`timescale 1ns/100ps
module lsc_sequence_counter_bench;
    import lsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // short delay cap keeps the pipeline sweep brief
    localparam int MD = 5;

    logic        ref_clk_in    = 1'b0;
    logic        rst_in        = 1'b1;
    logic        hsel_in       = 1'b0;
    logic [31:0] haddr_in      = 32'h0;
    logic [1:0]  htrans_in     = 2'h0;
    logic        hwrite_in     = 1'b0;
    logic [2:0]  hsize_in      = 3'h2;
    logic [31:0] hwdata_in     = 32'h0;
    logic        cascade_en_in = 1'b0;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    logic        tc_out;
    logic [31:0] state_out;
    logic [31:0] rd;
    int          err_count     = 0;
    int          tests_run     = 0;

    always #50 ref_clk_in = ~ref_clk_in;

    lsc_sequence_counter #(.MAX_DELAY(MD)) u_lsc_sequence_counter (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .hsel_in       (hsel_in),
        .haddr_in      (haddr_in),
        .htrans_in     (htrans_in),
        .hwrite_in     (hwrite_in),
        .hsize_in      (hsize_in),
        .hready_in     (hreadyout_out),
        .hwdata_in     (hwdata_in),
        .hrdata_out    (hrdata_out),
        .hreadyout_out (hreadyout_out),
        .hresp_out     (hresp_out),
        .cascade_en_in (cascade_en_in),
        .tc_out        (tc_out),
        .state_out     (state_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // compare, bus cycles and reference step
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy(output int n);
        n = 0;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1)
        begin
            @(posedge ref_clk_in);
            n++;
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel_in   <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in  <= {24'h0, a};
        hwrite_in <= w;
        wait_rdy(n);
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_rdy(n);
        rd = hrdata_out;
        check({31'h0, hresp_out}, 32'h0);
        // reads carry exactly one wait state
        check(32'(n), {31'h0, ~w});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    function automatic logic [31:0] msk(input logic [2:0] c);
        case (c)
            LEN_SEL_4:  return 32'h0000_000f;
            LEN_SEL_8:  return 32'h0000_00ff;
            LEN_SEL_16: return 32'h0000_ffff;
            LEN_SEL_24: return 32'h00ff_ffff;
            LEN_SEL_31: return 32'h7fff_ffff;
            default:    return 32'h0000_01ff;
        endcase
    endfunction

    // tap masks written out from the tap lists, stage k at bit k-1; multitap lists count from zero
    function automatic logic [31:0] nxt(input logic [31:0] s, input logic [2:0] c, input logic x);
        logic [31:0] t;
        case (c)
            LEN_SEL_4:  t = 32'h0000_0009;
            LEN_SEL_8:  t = 32'h0000_00b8;
            LEN_SEL_16: t = 32'h0000_b400;
            LEN_SEL_24: t = 32'h00e1_0000;
            LEN_SEL_31: t = 32'h4800_0000;
            default:    t = 32'h0000_0110;
        endcase
        return ((s << 1) | {31'h0, ^(s & t) ^ x}) & msk(c);
    endfunction

    function automatic logic [31:0] cw(input logic [2:0] c, input logic x, input logic au, input logic [1:0] b);
        return {22'h0, b, 2'b00, au, c, x, 1'b1};
    endfunction

    // load strobe, then state and control readback
    task automatic load(input logic [31:0] ctl, input logic [7:0] la, input logic [31:0] v, input logic [31:0] e);
        ahb(1'b1, la, v);
        ahb(1'b1, OFF_CTRL, ctl | 32'h40);
        repeat (2) @(posedge ref_clk_in);
        rdc(OFF_STATE, e);
        rdc(OFF_CTRL, ctl);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        #1;
        check(state_out, LFSR_RST);
        check({31'h0, tc_out}, 32'h0);
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rdc(OFF_CTRL, CTRL_RST);
        rdc(OFF_LOAD0, LOAD_RST);
        rdc(OFF_END0, END_RST);
        rdc(OFF_DELAY, 32'h0);
        rdc(OFF_STATUS, 32'h0);
        ahb(1'b1, OFF_DELAY, 32'h1f);
        rdc(OFF_DELAY, 32'(MD));
        ahb(1'b1, 8'h80, 32'h5a5a_5a5a);
        rdc(8'h80, 32'h0);
        $display("test reset done");
    endtask

    // load, step with cascade high, measure first return to start
    task automatic t_seq(input logic [2:0] c, input logic x, input logic [31:0] st, input int steps, input int per);
        logic [31:0] e;
        int          first;
        int          bad;
        e = st & msk(c);
        first = 0;
        bad = 0;
        load(cw(c, x, 1'b0, 2'h0), OFF_LOAD0, st, e);
        @(posedge ref_clk_in);
        cascade_en_in <= 1'b1;
        for (int i = 1; i <= steps; i++)
        begin
            @(posedge ref_clk_in);
            if (i == steps)
                cascade_en_in <= 1'b0;
            #1;
            e = nxt(e, c, x);
            if ((state_out & msk(c)) !== e)
                bad++;
            if (first == 0 && e == (st & msk(c)))
                first = i;
        end
        check(32'(bad), 32'h0);
        check(32'(first), 32'(per));
        // enable low must freeze every stage of the selected length
        repeat (3) @(posedge ref_clk_in);
        #1;
        check(state_out & msk(c), e);
        $display("test sequence length code %0d done", c);
    endtask

    // zero load is nudged off the lock state; bank 1 values are used
    task automatic t_lock;
        load(cw(LEN_SEL_9, 1'b0, 1'b0, 2'h1), 8'h14, 32'h0, 32'h1);
        load(cw(LEN_SEL_4, 1'b1, 1'b0, 2'h1), 8'h14, 32'hff, 32'he);
        $display("test lock state done");
    endtask

    // end detect, pipelined terminal count and auto reload
    task automatic t_tc(input int d);
        logic [31:0] e;
        int          n;
        e = nxt(nxt(nxt(32'hf, LEN_SEL_4, 1'b0), LEN_SEL_4, 1'b0), LEN_SEL_4, 1'b0);
        n = 0;
        ahb(1'b1, OFF_END0, e);
        ahb(1'b1, OFF_DELAY, 32'(d));
        ahb(1'b1, OFF_STATUS, 32'h0);
        load(cw(LEN_SEL_4, 1'b0, 1'b1, 2'h0), OFF_LOAD0, 32'hf, 32'hf);
        @(posedge ref_clk_in);
        cascade_en_in <= 1'b1;
        while (n < 40)
        begin
            @(posedge ref_clk_in);
            n++;
            #1;
            if (tc_out === 1'b1)
                break;
        end
        check(32'(n), 32'(4 + d));
        @(posedge ref_clk_in);
        cascade_en_in <= 1'b0;
        #1;
        check({31'h0, tc_out}, 32'h0);
        check(state_out & 32'hf, 32'hf);
        rdc(OFF_STATUS, 32'h1);
        ahb(1'b1, OFF_STATUS, 32'h0);
        rdc(OFF_STATUS, 32'h0);
        $display("test terminal count delay %0d done", d);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // closing and main sequence
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // the 16-bit full period dominates the run length
    initial
    begin
        repeat (80000) @(posedge ref_clk_in);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop;
    end

    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        t_reset;
        t_seq(LEN_SEL_4, 1'b0, 32'hf, 16, 15);
        t_seq(LEN_SEL_4, 1'b1, 32'h0, 16, 15);
        t_seq(LEN_SEL_8, 1'b0, 32'h1, 256, 255);
        t_seq(LEN_SEL_9, 1'b1, 32'h5, 512, 511);
        t_seq(LEN_SEL_16, 1'b0, 32'h1, 65536, 65535);
        t_seq(LEN_SEL_24, 1'b0, 32'h0012_3456, 64, 0);
        t_seq(LEN_SEL_31, 1'b1, 32'h0123_4567, 64, 0);
        t_lock;
        t_tc(0);
        t_tc(3);
        report_and_stop;
    end

endmodule // lsc_sequence_counter_bench
